// >>> asr_pkg.sv
package asr_pkg;
	localparam int ADDR_W = 17;
	localparam int DATA_W = 8;
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_READ_ACCESS_NS = 10;
	localparam int T_OE_ACCESS_NS = 5;
	localparam int T_WE_HIGHZ_NS = 5;
	localparam int T_DATA_SETUP_NS = 5;
	localparam int T_WRITE_PULSE_NS = 7;
	localparam int T_CS_TO_END_NS = 7;
	localparam int T_ADDR_TO_END_NS = 7;
	localparam int T_CS_HIGHZ_NS = 5;
	localparam int T_ADDR_HOLD_NS = 4;
	// least times round up to whole cycles; read access alone gets one more cycle for pin skew and output sampling
	localparam int RD_CYC = (T_READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int WZ_CYC = (T_WE_HIGHZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WS_CYC = (T_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WP_RAW = (T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WP_CYC = (WP_RAW > WS_CYC) ? WP_RAW : WS_CYC;
	localparam int TA_CYC = (T_CS_HIGHZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 4;

	typedef enum logic [2:0] {
		ASR_IDLE,
		ASR_RD,
		ASR_WZ,
		ASR_WP,
		ASR_TA
	} asr_state_type;

	typedef struct packed {
		logic              we;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} asr_req_type;

	typedef struct packed {
		logic              cs_n;
		logic              oe_n;
		logic              we_n;
		logic [ADDR_W-1:0] addr;
	} asr_pins_type;
endpackage : asr_pkg

// >>> asr_sync.sv
`timescale 1ns/1ns
module asr_sync (
	input  wire logic                      i_clk,
	input  wire logic                      i_rst_n,
	input  wire logic [asr_pkg::DATA_W-1:0] i_d,
	output logic      [asr_pkg::DATA_W-1:0] o_q
);
	logic [asr_pkg::DATA_W-1:0] s1_r;
	logic [asr_pkg::DATA_W-1:0] s2_r;

	// second stage is the only reader of the first
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_r <= 8'h00;
			s2_r <= 8'h00;
		end else begin
			s1_r <= i_d;
			s2_r <= s1_r;
		end
	end

	assign o_q = s2_r;
endmodule : asr_sync

// >>> asr_ctrl.sv
`timescale 1ns/1ns
// How it works
// R1: write lands only while select and strobe low
// R2: strobe held high through every read
// R3: strobe with output enable low: turn-off plus setup
// R4: output enable high: plain pulse width suffices
// R5: no bus drive while memory outputs active
// R6: select falls with strobe keeps memory quiet
// R7: select held low through write interval
// R8: address set before or with select falling
// R9: address valid 7 ns before write end
// R10: write data valid 5 ns before end
// R11: read data valid 10 ns after select
// R12: read data valid 5 ns after enable
// R13: memory floats within 5 ns after deselect
// R14: memory floats within 5 ns after strobe
// R15: memory drives no earlier than 3 ns after write
// R16: old read data held 4 ns after address change
// R17: 131072 bytes, 17-bit address
// R18: memory static, no clock or refresh
// R19: select and enable low with strobe high reads
module asr_ctrl (
	input  wire logic                        I_CLK_SYS,
	input  wire logic                        I_RST_N,
	input  wire logic                        I_REQ_VALID,
	input  wire asr_pkg::asr_req_type        I_REQ,
	output logic                             O_REQ_READY,
	output logic                             O_RD_VALID,
	output logic      [asr_pkg::DATA_W-1:0]  O_RD_DATA,
	output logic                             O_MEM_CS_N,
	output logic                             O_MEM_OE_N,
	output logic                             O_MEM_WE_N,
	output logic      [asr_pkg::ADDR_W-1:0]  O_MEM_ADDR,
	input  wire logic [asr_pkg::DATA_W-1:0]  I_MEM_DQ,
	output logic      [asr_pkg::DATA_W-1:0]  O_MEM_DQ,
	output logic                             O_MEM_DQ_OE_N
);
	asr_pkg::asr_state_type                  state_r, state_nxt;
	asr_pkg::asr_pins_type                   pins_r, pins_nxt;
	logic [asr_pkg::CNT_W-1:0]               cnt_r, cnt_nxt;
	logic [asr_pkg::DATA_W-1:0]              wdata_r, wdata_nxt;
	logic                                    dq_oe_n_r, dq_oe_n_nxt;
	logic [asr_pkg::DATA_W-1:0]              rdata_r, rdata_nxt;
	logic                                    rvalid_r, rvalid_nxt;
	logic [asr_pkg::DATA_W-1:0]              dq_sync;
	logic                                    cnt_done;

	localparam logic [asr_pkg::CNT_W-1:0] RD_N = asr_pkg::CNT_W'(asr_pkg::RD_CYC + 2);
	localparam logic [asr_pkg::CNT_W-1:0] WZ_N = asr_pkg::CNT_W'(asr_pkg::WZ_CYC);
	localparam logic [asr_pkg::CNT_W-1:0] WP_N = asr_pkg::CNT_W'(asr_pkg::WP_CYC);
	localparam logic [asr_pkg::CNT_W-1:0] TA_N = asr_pkg::CNT_W'(asr_pkg::TA_CYC);

	// data pins come from outside the clock domain
	asr_sync u_sync (
		.i_clk   (I_CLK_SYS),
		.i_rst_n (I_RST_N),
		.i_d     (I_MEM_DQ),
		.o_q     (dq_sync)
	);

	// every phase except idle ends when its countdown has drained
	assign cnt_done = (cnt_r == '0);

	// sequencer: phase and its countdown
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		if (!cnt_done) begin
			cnt_nxt = cnt_r - 1'b1;
		end
		case (state_r)
			asr_pkg::ASR_IDLE: begin
				if (I_REQ_VALID) begin
					if (I_REQ.we) begin
						cnt_nxt   = WZ_N;
						state_nxt = asr_pkg::ASR_WZ;
					end else begin
						cnt_nxt   = RD_N;
						state_nxt = asr_pkg::ASR_RD;
					end
				end
			end
			asr_pkg::ASR_RD: begin
				// wait covers select and enable access plus the synchroniser [R11] [R12]
				if (cnt_done) begin
					cnt_nxt   = TA_N;
					state_nxt = asr_pkg::ASR_TA;
				end
			end
			asr_pkg::ASR_WZ: begin
				// bus left alone until memory outputs have floated [R5] [R14]
				if (cnt_done) begin
					cnt_nxt   = WP_N;
					state_nxt = asr_pkg::ASR_WP;
				end
			end
			asr_pkg::ASR_WP: begin
				if (cnt_done) begin
					cnt_nxt   = TA_N;
					state_nxt = asr_pkg::ASR_TA;
				end
			end
			asr_pkg::ASR_TA: begin
				// gap lets memory float before the next select [R13] [R15]
				if (cnt_done) begin
					state_nxt = asr_pkg::ASR_IDLE;
				end
			end
			default: begin
				state_nxt = asr_pkg::ASR_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state_r <= asr_pkg::ASR_IDLE;
			cnt_r   <= '0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	// pin drive: select, enable, strobe and address
	always_comb begin
		pins_nxt = pins_r;
		case (state_r)
			asr_pkg::ASR_IDLE: begin
				if (I_REQ_VALID) begin
					// address first, select in the same edge [R8] [R17]
					pins_nxt.addr = I_REQ.addr;
					pins_nxt.cs_n = 1'b0;
					if (I_REQ.we) begin
						// enable kept high so strobe never meets driven outputs [R4] [R6]
						pins_nxt.oe_n = 1'b1;
						pins_nxt.we_n = 1'b0;
					end else begin
						pins_nxt.oe_n = 1'b0;
						pins_nxt.we_n = 1'b1; // [R2] [R19]
					end
				end
			end
			asr_pkg::ASR_RD: begin
				if (cnt_done) begin
					pins_nxt.cs_n = 1'b1;
					pins_nxt.oe_n = 1'b1;
				end
			end
			asr_pkg::ASR_WP: begin
				// address and select stand for the full pulse [R3] [R7] [R9] [R1]
				if (cnt_done) begin
					pins_nxt.we_n = 1'b1;
					pins_nxt.cs_n = 1'b1;
				end
			end
			default: begin
				pins_nxt = pins_r;
			end
		endcase
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			pins_r <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 17'h0_0000};
		end else begin
			pins_r <= pins_nxt;
		end
	end

	// bus drive: write byte and its enable
	always_comb begin
		wdata_nxt   = wdata_r;
		dq_oe_n_nxt = dq_oe_n_r;
		case (state_r)
			asr_pkg::ASR_IDLE: begin
				if (I_REQ_VALID && I_REQ.we) begin
					wdata_nxt = I_REQ.wdata;
				end
			end
			asr_pkg::ASR_WZ: begin
				// byte stands from here to the end of the pulse [R5] [R10]
				if (cnt_done) begin
					dq_oe_n_nxt = 1'b0;
				end
			end
			asr_pkg::ASR_TA: begin
				// data held one edge past write end [R16]
				dq_oe_n_nxt = 1'b1;
			end
			default: begin
				dq_oe_n_nxt = dq_oe_n_r;
			end
		endcase
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			wdata_r   <= 8'h00;
			dq_oe_n_r <= 1'b1;
		end else begin
			wdata_r   <= wdata_nxt;
			dq_oe_n_r <= dq_oe_n_nxt;
		end
	end

	// read capture: byte and its one-cycle strobe
	always_comb begin
		rdata_nxt  = rdata_r;
		rvalid_nxt = 1'b0;
		// sampled only after the fixed wait; the bus is not trusted earlier
		if ((state_r == asr_pkg::ASR_RD) && cnt_done) begin
			rdata_nxt  = dq_sync;
			rvalid_nxt = 1'b1;
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rdata_r  <= 8'h00;
			rvalid_r <= 1'b0;
		end else begin
			rdata_r  <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	// memory holds contents statically, so no idle refresh cycles [R18]
	assign O_REQ_READY   = (state_r == asr_pkg::ASR_IDLE);
	assign O_RD_VALID    = rvalid_r;
	assign O_RD_DATA     = rdata_r;
	assign O_MEM_CS_N    = pins_r.cs_n;
	assign O_MEM_OE_N    = pins_r.oe_n;
	assign O_MEM_WE_N    = pins_r.we_n;
	assign O_MEM_ADDR    = pins_r.addr;
	assign O_MEM_DQ      = wdata_r;
	assign O_MEM_DQ_OE_N = dq_oe_n_r;
endmodule : asr_ctrl

// >>> asr_ctrl_sva.sv
`timescale 1ns/1ns
module asr_ctrl_sva (
	input wire logic                 I_CLK_SYS,
	input wire logic                 I_RST_N,
	input wire logic                 I_REQ_VALID,
	input wire asr_pkg::asr_req_type I_REQ,
	input wire logic                 O_REQ_READY,
	input wire logic                 O_RD_VALID,
	input wire logic                 O_MEM_CS_N,
	input wire logic                 O_MEM_OE_N,
	input wire logic                 O_MEM_WE_N,
	input wire logic [16:0]          O_MEM_ADDR,
	input wire logic                 O_MEM_DQ_OE_N
);
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RST_N);
	wire tk = I_REQ_VALID && O_REQ_READY;
	a_no_fight: assert property (!O_MEM_DQ_OE_N |-> O_MEM_OE_N) else $error("fight");
	a_write_oe: assert property (!O_MEM_WE_N |-> O_MEM_OE_N && !O_MEM_CS_N) else $error("we");
	a_pulse_width: assert property (
		$fell(O_MEM_WE_N) |-> (!O_MEM_WE_N)[*2] ##[1:4] O_MEM_WE_N) else $error("pulse");
	a_data_setup: assert property (
		$rose(O_MEM_WE_N) |-> !O_MEM_DQ_OE_N && $past(!O_MEM_DQ_OE_N)) else $error("setup");
	a_addr_hold: assert property (
		!O_MEM_CS_N && $past(!O_MEM_CS_N) |-> $stable(O_MEM_ADDR)) else $error("addr");
	a_sel_addr: assert property (
		tk |=> !O_MEM_CS_N && O_MEM_ADDR == $past(I_REQ.addr)) else $error("sel");
	a_read_pins: assert property (tk && !I_REQ.we |=>
		(!O_MEM_CS_N && !O_MEM_OE_N && O_MEM_WE_N)[*5] ##1 O_MEM_CS_N) else $error("rd");
	a_read_ans: assert property (tk && !I_REQ.we |-> ##6 O_RD_VALID) else $error("ans");
	a_write_start: assert property (
		tk && I_REQ.we |=> O_MEM_DQ_OE_N && !O_MEM_WE_N) else $error("wr");
	c_rd: cover property (tk && !I_REQ.we);
	c_wr: cover property (tk && I_REQ.we);
	c_ans: cover property (O_RD_VALID);
endmodule : asr_ctrl_sva
bind asr_ctrl asr_ctrl_sva u_sva (.I_CLK_SYS, .I_RST_N, .I_REQ_VALID, .I_REQ, .O_REQ_READY,
	.O_RD_VALID, .O_MEM_CS_N, .O_MEM_OE_N, .O_MEM_WE_N, .O_MEM_ADDR, .O_MEM_DQ_OE_N);

// >>> asr_sram_model.sv
`timescale 1ns/1ns
module asr_sram_model #(parameter int DLY = 5) (
	input  wire logic        i_cs_n,
	input  wire logic        i_oe_n,
	input  wire logic        i_we_n,
	input  wire logic [16:0] i_addr,
	input  wire logic [7:0]  i_dq,
	output wire logic        o_drv,
	output wire logic [7:0]  o_dq
);
	logic [7:0] mem [0:131071]; // static, no refresh
	always @* if (!i_cs_n && !i_we_n) mem[i_addr] = i_dq;
	// worst-case lag; quiet while strobe low
	assign #DLY o_drv = !i_cs_n && !i_oe_n && i_we_n;
	assign #DLY o_dq = mem[i_addr]; // old byte lingers
endmodule : asr_sram_model

// >>> test_async_sram_byte_port.sv
`timescale 1ns/1ns
module test_async_sram_byte_port;
	logic                 clk = 1'b0;
	logic                 rst_n = 1'b0;
	logic                 req_valid = 1'b0;
	asr_pkg::asr_req_type req = '0;
	logic                 ready, rd_valid, cs_n, oe_n, we_n, dq_oe_n, m_drv;
	logic [16:0]          addr, ad [10];
	logic [7:0]           rd_data, c_dq, m_dq, bus, shadow [int], exp_q [$];
	int                   n_fail = 0, comparisons = 0, cyc = 0;
	always #5 clk = ~clk;
	// floating bus moves every cycle, never the stale byte
	assign bus = !dq_oe_n ? c_dq : (m_drv ? m_dq : ~cyc[7:0]);
	asr_ctrl dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_REQ_VALID(req_valid), .I_REQ(req),
		.O_REQ_READY(ready), .O_RD_VALID(rd_valid), .O_RD_DATA(rd_data), .O_MEM_CS_N(cs_n),
		.O_MEM_OE_N(oe_n), .O_MEM_WE_N(we_n), .O_MEM_ADDR(addr), .I_MEM_DQ(bus),
		.O_MEM_DQ(c_dq), .O_MEM_DQ_OE_N(dq_oe_n));
	asr_sram_model u_mem (.i_cs_n(cs_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(addr),
		.i_dq(bus), .o_drv(m_drv), .o_dq(m_dq));
	task automatic check(string nm, logic [7:0] e, logic [7:0] s);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : check
	task automatic print_verdict;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict
	// valid stays up while busy, so refused cycles are exercised too
	task automatic op(logic w, logic [16:0] a, logic [7:0] d);
		req_valid <= 1'b1;
		req <= '{we: w, addr: a, wdata: d};
		@(negedge clk);
		while (ready !== 1'b1) @(negedge clk);
		@(posedge clk);
		if (w) shadow[a] = d;
		else exp_q.push_back(shadow[a]);
		if ($urandom % 2) begin
			req_valid <= 1'b0;
			@(posedge clk);
		end
	endtask : op
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rd_valid === 1'b1)
			check("rd", exp_q.size() ? exp_q.pop_front() : 8'hxx, rd_data);
		if (cyc == 3000) begin
			n_fail++;
			print_verdict();
		end
	end
	initial begin
		void'($urandom(32'h3804_008e));
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 10; i++) begin
			ad[i] = (i < 2) ? {17{i[0]}} : 17'($urandom);
			op(1'b1, ad[i], 8'($urandom));
		end
		for (int i = 0; i < 10; i++) op(1'b0, ad[i], 8'($urandom));
		$display("test fill_read done");
		for (int i = 0; i < 8; i++) op(!i[0], ad[i / 2], 8'($urandom));
		// a request left standing would be taken again once idle
		req_valid <= 1'b0;
		$display("test overwrite done");
		repeat (20) @(posedge clk);
		check("left", 8'h00, 8'(exp_q.size()));
		print_verdict();
	end
endmodule : test_async_sram_byte_port
